// *** rtl/icp_pkg.sv ***
// Purpose: Shared constants for the instruction cache and prefetch block
// Assumes: 32-bit addresses, long-word entries
// Notes:   Address split is tag | index | half | byte
package icp_pkg;
    localparam int ICP_ADDR_W   = 32;
    localparam int ICP_DATA_W   = 32;
    localparam int ICP_HALF_W   = 16;
    localparam int ICP_ENTRIES  = 64;
    localparam int ICP_IDX_W    = 6;
    localparam int ICP_IDX_LSB  = 2;
    localparam int ICP_HALF_BIT = 1;
    localparam int ICP_TAG_LSB  = 8;
    localparam int ICP_TAG_W    = 24;
    localparam int ICP_WA_W     = 30;

    typedef enum logic [1:0] {
        ICP_IDLE,
        ICP_FILL,
        ICP_OPER
    } icp_state_e;
endpackage

// *** rtl/icp_cache.sv ***
// Purpose: Direct-mapped instruction cache with prefetch hold buffer and bus arbitration
// Assumes: Prefetch and operand requesters hold req until answered; bus_ack_i is a pulse
// Notes:   All ports share core_clk_i, so no synchronisers are needed
`timescale 1ns/1ps
`default_nettype none

module icp_cache
    import icp_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  cache_en_i,
    input  wire logic                  pf_req_i,
    input  wire logic [ICP_ADDR_W-1:0] pf_addr_i,
    input  wire logic                  supervisor_space_bit_i,
    output var  logic                  pf_ack_o,
    output var  logic [ICP_HALF_W-1:0] pf_data_o,
    input  wire logic                  op_req_i,
    input  wire logic [ICP_ADDR_W-1:0] op_addr_i,
    output var  logic                  op_done_o,
    output var  logic                  bus_req_o,
    output var  logic                  bus_op_o,
    output var  logic [ICP_ADDR_W-1:0] bus_addr_o,
    output var  logic                  bus_super_o,
    input  wire logic                  bus_ack_i,
    input  wire logic [ICP_DATA_W-1:0] bus_data_i
);

    // ****************************************
    // Storage
    // ****************************************
    // 64 long-word entries
    logic [ICP_ENTRIES-1:0] valid_q;
    logic [ICP_TAG_W-1:0]   tag_q   [ICP_ENTRIES];
    logic                   space_q [ICP_ENTRIES];
    logic [ICP_DATA_W-1:0]  data_q  [ICP_ENTRIES];

    logic [ICP_WA_W-1:0]    hold_wa_q;
    logic                   hold_super_q;
    logic                   hold_vld_q;
    logic [ICP_DATA_W-1:0]  hold_data_q;

    icp_state_e             state_q;
    icp_state_e             state_d;
    logic                   pf_ack_q;
    logic                   pf_ack_d;
    logic [ICP_HALF_W-1:0]  pf_data_q;
    logic [ICP_HALF_W-1:0]  pf_data_d;
    logic                   op_done_q;
    logic                   op_done_d;
    logic                   bus_req_q;
    logic                   bus_req_d;
    logic                   bus_op_q;
    logic                   bus_op_d;
    logic [ICP_ADDR_W-1:0]  bus_addr_q;
    logic [ICP_ADDR_W-1:0]  bus_addr_d;
    logic                   bus_super_q;
    logic                   bus_super_d;

    // ****************************************
    // Lookup
    // ****************************************
    logic [ICP_IDX_W-1:0]   idx;
    logic [ICP_TAG_W-1:0]   tag;
    logic [ICP_WA_W-1:0]    pf_wa;
    logic                   cache_hit;
    logic                   hold_hit;
    logic                   hit;
    logic                   pf_new;
    logic                   fill_done;
    logic                   fill_wr;
    logic [ICP_DATA_W-1:0]  hit_word;

    always_comb begin
        idx      = pf_addr_i[ICP_IDX_LSB +: ICP_IDX_W];
        tag      = pf_addr_i[ICP_TAG_LSB +: ICP_TAG_W];
        pf_wa    = pf_addr_i[ICP_ADDR_W-1:ICP_IDX_LSB];
        cache_hit = cache_en_i && valid_q[idx] && (tag_q[idx] == tag)
                    && (space_q[idx] == supervisor_space_bit_i);
        // hold buffer serves when cache off
        hold_hit  = !cache_en_i && hold_vld_q && (hold_wa_q == pf_wa)
                    && (hold_super_q == supervisor_space_bit_i);
        hit       = cache_hit || hold_hit;
        hit_word  = cache_hit ? data_q[idx] : hold_data_q;
        pf_new    = pf_req_i && !pf_ack_q;
        fill_done = (state_q == ICP_FILL) && bus_ack_i;
        fill_wr   = fill_done && cache_en_i;
    end

    // ****************************************
    // Control and bus sequencing
    // ****************************************
    always_comb begin
        state_d     = state_q;
        pf_ack_d    = 1'b0;
        pf_data_d   = pf_data_q;
        op_done_d   = 1'b0;
        bus_req_d   = bus_req_q;
        bus_op_d    = bus_op_q;
        bus_addr_d  = bus_addr_q;
        bus_super_d = bus_super_q;
        // hits answered without a bus cycle
        if (pf_new && hit) begin
            pf_ack_d  = 1'b1;
            pf_data_d = pf_addr_i[ICP_HALF_BIT] ? hit_word[ICP_HALF_W-1:0]
                                                : hit_word[ICP_DATA_W-1:ICP_HALF_W];
        end
        case (state_q)
            ICP_IDLE: begin
                // operand goes first when prefetch hits
                if (op_req_i && (!pf_new || hit)) begin
                    state_d     = ICP_OPER;
                    bus_req_d   = 1'b1;
                    bus_op_d    = 1'b1;
                    bus_addr_d  = op_addr_i;
                    bus_super_d = supervisor_space_bit_i;
                end else if (pf_new && !hit) begin
                    state_d     = ICP_FILL;
                    bus_req_d   = 1'b1;
                    bus_op_d    = 1'b0;
                    bus_addr_d  = {pf_wa, 2'b00};
                    bus_super_d = supervisor_space_bit_i;
                end
            end
            ICP_FILL: begin
                if (bus_ack_i) begin
                    state_d   = ICP_IDLE;
                    bus_req_d = 1'b0;
                    pf_ack_d  = 1'b1;
                    // requested half of the fetched long word
                    pf_data_d = pf_addr_i[ICP_HALF_BIT] ? bus_data_i[ICP_HALF_W-1:0]
                                                        : bus_data_i[ICP_DATA_W-1:ICP_HALF_W];
                end
            end
            ICP_OPER: begin
                if (bus_ack_i) begin
                    state_d   = ICP_IDLE;
                    bus_req_d = 1'b0;
                    op_done_d = 1'b1;
                end
            end
            default: begin
                state_d   = ICP_IDLE;
                bus_req_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            state_q     <= ICP_IDLE;
            pf_ack_q    <= 1'b0;
            pf_data_q   <= 16'h0000;
            op_done_q   <= 1'b0;
            bus_req_q   <= 1'b0;
            bus_op_q    <= 1'b0;
            bus_addr_q  <= 32'h00000000;
            bus_super_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            pf_ack_q    <= pf_ack_d;
            pf_data_q   <= pf_data_d;
            op_done_q   <= op_done_d;
            bus_req_q   <= bus_req_d;
            bus_op_q    <= bus_op_d;
            bus_addr_q  <= bus_addr_d;
            bus_super_q <= bus_super_d;
        end
    end

    // ****************************************
    // Entry and hold buffer update
    // ****************************************
    logic [ICP_ENTRIES-1:0] valid_d;

    always_comb begin
        valid_d = valid_q;
        if (fill_wr) begin
            valid_d[idx] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            valid_q    <= '0;
            hold_vld_q <= 1'b0;
        end else begin
            valid_q <= valid_d;
            if (fill_done) begin
                hold_vld_q   <= 1'b1;
                hold_wa_q    <= bus_addr_q[ICP_ADDR_W-1:ICP_IDX_LSB];
                hold_super_q <= bus_super_q;
                hold_data_q  <= bus_data_i;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (fill_wr) begin
            tag_q[idx]   <= tag;
            space_q[idx] <= bus_super_q;
            data_q[idx]  <= bus_data_i;
        end
    end

    assign pf_ack_o    = pf_ack_q;
    assign pf_data_o   = pf_data_q;
    assign op_done_o   = op_done_q;
    assign bus_req_o   = bus_req_q;
    assign bus_op_o    = bus_op_q;
    assign bus_addr_o  = bus_addr_q;
    assign bus_super_o = bus_super_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    property p_fill_valid;
        fill_wr |=> valid_q[$past(idx)];
    endproperty
    a_fill_valid: assert property (p_fill_valid) else $error("Fill did not set valid");

    property p_hit_tag;
        (state_q == ICP_IDLE) && pf_new && cache_en_i && !op_req_i && valid_q[idx]
            && ((tag_q[idx] != pf_addr_i[ICP_TAG_LSB +: ICP_TAG_W])
                || (space_q[idx] != supervisor_space_bit_i))
            |=> bus_req_o && !bus_op_o && !pf_ack_o;
    endproperty
    a_hit_tag: assert property (p_hit_tag) else $error("Hit without tag match");

    property p_invalid_miss;
        (state_q == ICP_IDLE) && pf_new && cache_en_i && !op_req_i && !valid_q[idx]
            |=> bus_req_o && !bus_op_o && !pf_ack_o;
    endproperty
    a_invalid_miss: assert property (p_invalid_miss) else $error("Invalid entry hit");

    property p_aligned;
        bus_req_o && !bus_op_o |-> bus_addr_o[1:0] == 2'b00;
    endproperty
    a_aligned: assert property (p_aligned) else $error("Unaligned instruction fetch");

    property p_hit_no_bus;
        (state_q == ICP_IDLE) && pf_new && cache_hit && !op_req_i |=> !bus_req_o ##0 pf_ack_o;
    endproperty
    a_hit_no_bus: assert property (p_hit_no_bus) else $error("Hit started bus cycle");

    property p_hold_no_bus;
        (state_q == ICP_IDLE) && pf_new && hold_hit && !op_req_i |=> !bus_req_o && pf_ack_o;
    endproperty
    a_hold_no_bus: assert property (p_hold_no_bus) else $error("Hold hit used bus");

    property p_op_first;
        (state_q == ICP_IDLE) && op_req_i && pf_new && hit |=> bus_req_o && bus_op_o && pf_ack_o;
    endproperty
    a_op_first: assert property (p_op_first) else $error("Operand waited on hit");

    property p_hit_in_oper;
        (state_q == ICP_OPER) && pf_new && hit |=> pf_ack_o ##1 !pf_ack_o;
    endproperty
    a_hit_in_oper: assert property (p_hit_in_oper) else $error("Hit stalled by operand");

    property p_half_sel;
        (state_q == ICP_IDLE) && pf_new && cache_hit |=>
            pf_data_o == ($past(pf_addr_i[1]) ? $past(hit_word[15:0]) : $past(hit_word[31:16]));
    endproperty
    a_half_sel: assert property (p_half_sel) else $error("Wrong half delivered");

    c_fill:    cover property (fill_wr ##[1:8] (pf_new && cache_hit));
    c_hold:    cover property (pf_new && hold_hit);
    c_op_hit:  cover property ((state_q == ICP_OPER) && pf_new && hit);

endmodule

`default_nettype wire

// *** dv/icp_bus_model.sv ***
// Purpose: Bus controller model facing icp_cache
// Assumes: One bus cycle at a time
// Notes:   Acks after lat_i cycles; idle data toggles
`timescale 1ns/1ps
`default_nettype none
module icp_bus_model
    import icp_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rstn_i,
    input  wire logic                  req_i,
    input  wire logic [ICP_ADDR_W-1:0] addr_i,
    input  wire logic                  super_i,
    input  wire logic [7:0]            lat_i,
    output var  logic                  ack_o,
    output var  logic [ICP_DATA_W-1:0] data_o
);
    logic [7:0] cnt_q;

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            ack_o  <= 1'b0;
            data_o <= 32'h00000000;
        end else if (req_i && !ack_o && cnt_q >= lat_i) begin
            ack_o  <= 1'b1;
            data_o <= {addr_i[23:8] ^ {16{super_i}}, addr_i[15:0] ^ addr_i[31:16] ^ 16'h0F0F};
        end else begin
            ack_o  <= 1'b0;
            data_o <= ~data_o;
        end
        cnt_q <= (rstn_i && req_i && !ack_o) ? cnt_q + 8'h01 : 8'h00;
    end
endmodule
`default_nettype wire

// *** dv/tb_instruction_cache_prefetch.sv ***
// Purpose: Self-checking bench for icp_cache
// Assumes: 20 MHz clock, synchronous active-low reset
// Notes:   Bus cycles counted at each acked edge
`timescale 1ns/1ps
`default_nettype none
module tb_instruction_cache_prefetch
    import icp_pkg::*;
;
    logic        clk, rstn, en, sup, pf_req, pf_ack, op_req, op_done;
    logic        bus_req, bus_op, bus_super, bus_ack, last_sup;
    logic [31:0] pf_addr, op_addr, bus_addr, bus_data, last_addr;
    logic [15:0] pf_data;
    logic [7:0]  lat;
    int          mismatches, n_compared;
    int          n_fetch = 0;
    int          n_oper = 0;
    localparam logic [31:0] A = 32'h12345670;
    localparam logic [31:0] B = 32'h00004000;

    icp_cache dut (.core_clk_i(clk), .resetn_i(rstn), .cache_en_i(en), .pf_req_i(pf_req),
        .pf_addr_i(pf_addr), .supervisor_space_bit_i(sup), .pf_ack_o(pf_ack),
        .pf_data_o(pf_data), .op_req_i(op_req), .op_addr_i(op_addr), .op_done_o(op_done),
        .bus_req_o(bus_req), .bus_op_o(bus_op), .bus_addr_o(bus_addr),
        .bus_super_o(bus_super), .bus_ack_i(bus_ack), .bus_data_i(bus_data));
    icp_bus_model u_bus (.clk_i(clk), .rstn_i(rstn), .req_i(bus_req), .addr_i(bus_addr),
        .super_i(bus_super), .lat_i(lat), .ack_o(bus_ack), .data_o(bus_data));

    always @(posedge clk) begin
        if (bus_req && bus_ack) begin
            n_oper    <= n_oper + (bus_op ? 1 : 0);
            n_fetch   <= n_fetch + (bus_op ? 0 : 1);
            last_addr <= bus_addr;
            last_sup  <= bus_super;
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] exp_w(input logic [31:0] a, input logic s);
        logic [31:0] w;
        w = {a[23:8] ^ {16{s}}, {a[15:2], 2'b00} ^ a[31:16] ^ 16'h0F0F};
        return a[1] ? w[15:0] : w[31:16];
    endfunction

    task automatic final_report();
        $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic pf(input logic [31:0] a, input int fills);
        int f0;
        int k;
        f0 = n_fetch;
        k = 0;
        @(posedge clk);
        pf_req  <= 1'b1;
        pf_addr <= a;
        do begin
            @(negedge clk);
            k++;
            if (k > 200) begin
                mismatches++;
                final_report();
            end
        end while (pf_ack !== 1'b1);
        @(posedge clk);
        pf_req <= 1'b0;
        chk(32'(pf_data), 32'(exp_w(a, sup)));
        chk(32'(n_fetch - f0), 32'(fills));
        if (fills == 0) begin
            chk(32'(k), 32'd2);
        end
    endtask

    task automatic oper(input logic [31:0] a);
        int k;
        k = 0;
        @(posedge clk);
        op_req  <= 1'b1;
        op_addr <= a;
        do begin
            @(negedge clk);
            k++;
            if (k > 200) begin
                mismatches++;
                final_report();
            end
            if (k == 2) chk(32'({bus_req, bus_op}), 32'h3);
        end while (bus_ack !== 1'b1 || bus_op !== 1'b1);
        @(posedge clk);
        op_req <= 1'b0;
        @(negedge clk);
        chk(32'(op_done), 32'h1);
        chk(last_addr, a);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_fill();
        pf(A, 1);
        chk(last_addr, {A[31:2], 2'b00});
        chk(32'(last_sup), 32'(sup));
        pf(A + 32'h2, 0);
    endtask

    task automatic s_sweep();
        for (int i = 0; i < 64; i++) pf(B + 32'(i * 4 + 2), 1);
        for (int i = 0; i < 64; i++) pf(B + 32'(i * 4), 0);
        pf(B + 32'h100, 1);
        pf(B + 32'h100, 0);
        @(posedge clk);
        sup <= 1'b1;
        pf(B + 32'h100, 1);
        chk(32'(last_sup), 32'h1);
        @(posedge clk);
        sup <= 1'b0;
    endtask

    task automatic s_disabled();
        do_reset();
        pf(A, 1);
        @(posedge clk);
        en <= 1'b0;
        pf(B, 1);
        pf(B + 32'h2, 0);
        pf(A + 32'h2, 1);
        @(posedge clk);
        en <= 1'b1;
        pf(A, 0);
    endtask

    task automatic s_parallel();
        int o0;
        o0 = n_oper;
        @(posedge clk);
        lat <= 8'h14;
        fork
            oper(32'h00009000);
            begin
                pf(A, 0);
                pf(A + 32'h2, 0);
                pf(A, 0);
            end
        join
        chk(32'(n_oper - o0), 32'h1);
        @(posedge clk);
        lat <= 8'h02;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        {rstn, sup, pf_req, op_req} = 4'h0;
        {en, pf_addr, op_addr, lat} = {1'b1, 64'h0, 8'h02};
        {mismatches, n_compared} = '0;
        do_reset();
        s_fill();
        s_sweep();
        s_disabled();
        s_parallel();
        final_report();
    end
endmodule
`default_nettype wire
